/* rtl/modbus_rtu_cfg.svh */
// Constants for the RTU readout slave: link timing, function codes and register map
`ifndef MODBUS_RTU_CFG_SVH
`define MODBUS_RTU_CFG_SVH

`define MB_CLK_HZ 200000000
`define MB_BAUD 19200
`define MB_BIT_CYCLES ((`MB_CLK_HZ + `MB_BAUD / 2) / `MB_BAUD)
`define MB_CHAR_BITS 10
`define MB_GAP_CHARS 7
`define MB_ADDR_MODULUS 32'h00000064

`define MB_FC_READ_HOLDING 8'h03
`define MB_FC_EXC_FLAG 8'h80
`define MB_EXC_ILLEGAL_FUNC 8'h01
`define MB_EXC_ILLEGAL_ADDR 8'h02
`define MB_EXC_ILLEGAL_VALUE 8'h03
`define MB_BROADCAST 8'h00

`define MB_REG_PRESSURE 16'h0002
`define MB_REG_FLOW 16'h0006
`define MB_REG_CONSUMPTION 16'h0008
`define MB_MAX_QTY 8
`define MB_PROTO_MAX_QTY 16'h007D

`define MB_REQ_BYTES 8
`define MB_MIN_FRAME 4
`define MB_HDR_BYTES 8'h03
`define MB_CRC_INIT 16'hFFFF
`define MB_CRC_POLY 16'hA001

`endif

/* rtl/modbus_rtu_pkg.sv */
// State types of the RTU readout slave
`default_nettype none
package modbus_rtu_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOAD = 2'b01,
        TX_SEND = 2'b11
    } tx_state_t;
endpackage
`default_nettype wire

/* rtl/modbus_rtu_readout_slave.sv */
// RTU serial slave answering holding-register reads of three 32-bit measurements
`timescale 1ns/1ps
`default_nettype none
`include "modbus_rtu_cfg.svh"

// Overview of operation
// - Link runs RTU framing at 19200 baud by default.
// - Characters are eight data bits, no parity, one stop bit.
// - Slave address is the serial number modulo one hundred.
// - Function 03 reads of up to MAX_QTY mapped registers are answered with the requested values.
// - Four-byte values go out as byte 1, byte 0, byte 3, byte 2.
// - Each sixteen-bit register word goes high byte first, low byte second; the CRC goes low byte first.
module modbus_rtu_readout_slave
    import modbus_rtu_pkg::*;
#(
    parameter int BIT_CYCLES = `MB_BIT_CYCLES,
    parameter int GAP_CHARS = `MB_GAP_CHARS,
    parameter int MAX_QTY = `MB_MAX_QTY
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_rx,
    input wire logic [31:0] i_serial_number,
    input wire logic [31:0] i_pressure_value,
    input wire logic [31:0] i_volumetric_flow_value,
    input wire logic [31:0] i_total_consumption_count,
    output logic o_tx,
    output logic o_tx_en,
    output logic [7:0] o_slave_address
);
    localparam int GAP_CYCLES = GAP_CHARS * `MB_CHAR_BITS * BIT_CYCLES;
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
    localparam logic [23:0] GAP_LAST = 24'(GAP_CYCLES - 1);
    localparam logic [23:0] GAP_FULL = 24'(GAP_CYCLES);

    if (BIT_CYCLES < 4 || BIT_CYCLES > 65535 || GAP_CHARS < 1 || GAP_CYCLES > 16777214
        || MAX_QTY < 1 || MAX_QTY > 125) begin : g_bad_params
        $error("modbus_rtu_readout_slave: unsupported parameter values");
    end

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ `MB_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic reg_mapped(input logic [15:0] a);
        return a == `MB_REG_PRESSURE || a == `MB_REG_PRESSURE + 16'h0001
            || a == `MB_REG_FLOW || a == `MB_REG_FLOW + 16'h0001
            || a == `MB_REG_CONSUMPTION || a == `MB_REG_CONSUMPTION + 16'h0001;
    endfunction

    // Lower register of a channel holds bytes 1:0, the upper one bytes 3:2
    function automatic logic [15:0] reg_word(input logic [15:0] a, input logic [31:0] p,
                                             input logic [31:0] f, input logic [31:0] c);
        if (a == `MB_REG_PRESSURE) return p[15:0];
        else if (a == `MB_REG_PRESSURE + 16'h0001) return p[31:16];
        else if (a == `MB_REG_FLOW) return f[15:0];
        else if (a == `MB_REG_FLOW + 16'h0001) return f[31:16];
        else if (a == `MB_REG_CONSUMPTION) return c[15:0];
        else if (a == `MB_REG_CONSUMPTION + 16'h0001) return c[31:16];
        else return 16'h0000;
    endfunction

    // Receive group
    rx_state_t rx_state, next_rx_state;
    logic [15:0] rx_cnt, next_rx_cnt;
    logic [2:0] rx_bit, next_rx_bit;
    logic [7:0] rx_shift, next_rx_shift;
    logic [3:0] rx_count, next_rx_count;
    logic rx_bad, next_rx_bad;
    logic [15:0] rx_crc, next_rx_crc;
    logic [23:0] gap_cnt, next_gap_cnt;
    logic [7:0] rx_buf [0:`MB_REQ_BYTES-1];
    logic [7:0] next_rx_buf [0:`MB_REQ_BYTES-1];
    logic [7:0] slave_addr, next_slave_addr;
    logic addr_loaded, next_addr_loaded;
    logic frame_end;

    // Transmit group
    tx_state_t tx_state, next_tx_state;
    logic [15:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_bit, next_tx_bit;
    logic [9:0] tx_shift, next_tx_shift;
    logic [7:0] tx_idx, next_tx_idx;
    logic [7:0] tx_len, next_tx_len;
    logic [15:0] tx_crc, next_tx_crc;
    logic resp_exc, next_resp_exc;
    logic [7:0] resp_code, next_resp_code;
    logic [15:0] resp_start, next_resp_start;
    logic [7:0] resp_qty, next_resp_qty;
    logic [31:0] snap_p, next_snap_p;
    logic [31:0] snap_f, next_snap_f;
    logic [31:0] snap_c, next_snap_c;
    logic next_tx_line, next_tx_en;
    logic rx_ok;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_shift = rx_shift;
        next_rx_count = rx_count;
        next_rx_bad = rx_bad;
        next_rx_crc = rx_crc;
        next_gap_cnt = gap_cnt;
        next_rx_buf = rx_buf;
        frame_end = 1'b0;
        // Strap-like capture one cycle after reset release, then held
        next_slave_addr = addr_loaded ? slave_addr
                                      : 8'(i_serial_number % `MB_ADDR_MODULUS);
        next_addr_loaded = 1'b1;
        if (tx_state != TX_IDLE) begin
            // Our own reply echoes on the shared pair; it is never a request
            next_rx_state = RX_IDLE;
            next_gap_cnt = 24'h000000;
            next_rx_count = 4'h0;
            next_rx_bad = 1'b0;
            next_rx_crc = `MB_CRC_INIT;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (!i_rx) begin
                        next_rx_state = RX_START;
                        next_rx_cnt = 16'h0000;
                    end
                end
                RX_START: begin
                    if (rx_cnt == BIT_HALF) begin
                        next_rx_cnt = 16'h0000;
                        next_rx_bit = 3'h0;
                        next_rx_state = i_rx ? RX_IDLE : RX_DATA;
                    end else begin
                        next_rx_cnt = rx_cnt + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt == BIT_LAST) begin
                        next_rx_cnt = 16'h0000;
                        next_rx_shift = {i_rx, rx_shift[7:1]};
                        next_rx_bit = rx_bit + 3'h1;
                        if (rx_bit == 3'h7) begin
                            next_rx_state = RX_STOP;
                        end
                    end else begin
                        next_rx_cnt = rx_cnt + 16'h0001;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt == BIT_LAST) begin
                        next_rx_state = RX_IDLE;
                        if (!i_rx) begin
                            next_rx_bad = 1'b1;
                        end else begin
                            if (rx_count < 4'(`MB_REQ_BYTES)) begin
                                next_rx_buf[rx_count[2:0]] = rx_shift;
                            end
                            if (rx_count != 4'hF) begin
                                next_rx_count = rx_count + 4'h1;
                            end
                            next_rx_crc = crc_step(rx_crc, rx_shift);
                        end
                    end else begin
                        next_rx_cnt = rx_cnt + 16'h0001;
                    end
                end
            endcase
            if (rx_state != RX_IDLE || !i_rx) begin
                next_gap_cnt = 24'h000000;
            end else if (gap_cnt < GAP_FULL) begin
                next_gap_cnt = gap_cnt + 24'h000001;
            end
            if (rx_state == RX_IDLE && i_rx && gap_cnt == GAP_LAST && rx_count != 4'h0) begin
                frame_end = 1'b1;
                next_rx_count = 4'h0;
                next_rx_bad = 1'b0;
                next_rx_crc = `MB_CRC_INIT;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 16'h0000;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            rx_count <= 4'h0;
            rx_bad <= 1'b0;
            rx_crc <= `MB_CRC_INIT;
            gap_cnt <= 24'h000000;
            for (int i = 0; i < `MB_REQ_BYTES; i++) begin
                rx_buf[i] <= 8'h00;
            end
            slave_addr <= 8'h00;
            addr_loaded <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_shift <= next_rx_shift;
            rx_count <= next_rx_count;
            rx_bad <= next_rx_bad;
            rx_crc <= next_rx_crc;
            gap_cnt <= next_gap_cnt;
            rx_buf <= next_rx_buf;
            slave_addr <= next_slave_addr;
            addr_loaded <= next_addr_loaded;
        end
    end

    assign o_slave_address = slave_addr;

    always_comb begin
        logic [15:0] req_start;
        logic [15:0] req_qty;
        logic range_bad;
        logic [7:0] k_off;
        logic [15:0] word;
        logic [7:0] cur_byte;
        req_start = {rx_buf[2], rx_buf[3]};
        req_qty = {rx_buf[4], rx_buf[5]};
        range_bad = 1'b0;
        cur_byte = 8'h00;
        for (int k = 0; k < MAX_QTY; k++) begin
            if (16'(k) < req_qty && !reg_mapped(req_start + 16'(k))) begin
                range_bad = 1'b1;
            end
        end
        k_off = tx_idx - `MB_HDR_BYTES;
        word = reg_word(resp_start + {9'h000, k_off[7:1]}, snap_p, snap_f, snap_c);
        if (tx_idx == 8'h00) begin
            cur_byte = slave_addr;
        end else if (tx_idx == 8'h01) begin
            cur_byte = resp_exc ? (`MB_FC_READ_HOLDING | `MB_FC_EXC_FLAG)
                                : `MB_FC_READ_HOLDING;
        end else if (tx_idx == 8'h02) begin
            cur_byte = resp_exc ? resp_code : {resp_qty[6:0], 1'b0};
        end else if (tx_idx < tx_len) begin
            cur_byte = k_off[0] ? word[7:0] : word[15:8];
        end else if (tx_idx == tx_len) begin
            cur_byte = tx_crc[7:0];
        end else begin
            cur_byte = tx_crc[15:8];
        end
        rx_ok = frame_end && !rx_bad && rx_count >= 4'(`MB_MIN_FRAME) && rx_crc == 16'h0000
            && rx_buf[0] == slave_addr && rx_buf[0] != `MB_BROADCAST;
        next_tx_state = tx_state;
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        next_tx_shift = tx_shift;
        next_tx_idx = tx_idx;
        next_tx_len = tx_len;
        next_tx_crc = tx_crc;
        next_resp_exc = resp_exc;
        next_resp_code = resp_code;
        next_resp_start = resp_start;
        next_resp_qty = resp_qty;
        next_snap_p = snap_p;
        next_snap_f = snap_f;
        next_snap_c = snap_c;
        unique case (tx_state)
            TX_IDLE: begin
                if (rx_ok && (rx_buf[1] != `MB_FC_READ_HOLDING
                              || rx_count == 4'(`MB_REQ_BYTES))) begin
                    // Reply starts in the cycle after the gap closes, no added delay
                    next_tx_state = TX_LOAD;
                    next_tx_idx = 8'h00;
                    next_tx_crc = `MB_CRC_INIT;
                    next_tx_len = `MB_HDR_BYTES;
                    next_resp_exc = 1'b1;
                    // One snapshot keeps both halves of a value coherent
                    next_snap_p = i_pressure_value;
                    next_snap_f = i_volumetric_flow_value;
                    next_snap_c = i_total_consumption_count;
                    if (rx_buf[1] != `MB_FC_READ_HOLDING) begin
                        next_resp_code = `MB_EXC_ILLEGAL_FUNC;
                    end else if (req_qty == 16'h0000 || req_qty > `MB_PROTO_MAX_QTY) begin
                        next_resp_code = `MB_EXC_ILLEGAL_VALUE;
                    end else if (req_qty > 16'(MAX_QTY) || range_bad) begin
                        next_resp_code = `MB_EXC_ILLEGAL_ADDR;
                    end else begin
                        next_resp_exc = 1'b0;
                        next_resp_start = req_start;
                        next_resp_qty = req_qty[7:0];
                        next_tx_len = {req_qty[6:0], 1'b0} + `MB_HDR_BYTES;
                    end
                end
            end
            TX_LOAD: begin
                next_tx_shift = {1'b1, cur_byte, 1'b0};
                if (tx_idx < tx_len) begin
                    next_tx_crc = crc_step(tx_crc, cur_byte);
                end
                next_tx_idx = tx_idx + 8'h01;
                next_tx_bit = 4'h0;
                next_tx_cnt = 16'h0000;
                next_tx_state = TX_SEND;
            end
            TX_SEND: begin
                if (tx_cnt == BIT_LAST) begin
                    next_tx_cnt = 16'h0000;
                    next_tx_shift = {1'b1, tx_shift[9:1]};
                    next_tx_bit = tx_bit + 4'h1;
                    if (tx_bit == 4'h9) begin
                        next_tx_state = (tx_idx == tx_len + 8'h02) ? TX_IDLE : TX_LOAD;
                    end
                end else begin
                    next_tx_cnt = tx_cnt + 16'h0001;
                end
            end
            default: begin
                next_tx_state = TX_IDLE;
            end
        endcase
        next_tx_line = (next_tx_state == TX_SEND) ? next_tx_shift[0] : 1'b1;
        next_tx_en = next_tx_state != TX_IDLE;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tx_state <= TX_IDLE;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3FF;
            tx_idx <= 8'h00;
            tx_len <= 8'h00;
            tx_crc <= `MB_CRC_INIT;
            resp_exc <= 1'b0;
            resp_code <= 8'h00;
            resp_start <= 16'h0000;
            resp_qty <= 8'h00;
            snap_p <= 32'h00000000;
            snap_f <= 32'h00000000;
            snap_c <= 32'h00000000;
            o_tx <= 1'b1;
            o_tx_en <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_shift <= next_tx_shift;
            tx_idx <= next_tx_idx;
            tx_len <= next_tx_len;
            tx_crc <= next_tx_crc;
            resp_exc <= next_resp_exc;
            resp_code <= next_resp_code;
            resp_start <= next_resp_start;
            resp_qty <= next_resp_qty;
            snap_p <= next_snap_p;
            snap_f <= next_snap_f;
            snap_c <= next_snap_c;
            o_tx <= next_tx_line;
            o_tx_en <= next_tx_en;
        end
    end

    a_line_idle_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_tx_en |-> o_tx) else $error("line not idle high while undriven");
    a_start_bit_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_tx_en) |=> !o_tx) else $error("no start bit after driver enable");
    a_stop_bit_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_SEND && tx_bit == 4'h9) |-> o_tx) else $error("stop bit low");
    a_bit_hold_time: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_SEND && tx_cnt != BIT_LAST) |=> $stable(o_tx))
        else $error("line changed inside a bit");
    a_reply_prompt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_IDLE && next_tx_state == TX_LOAD) |=> o_tx_en ##1 !o_tx)
        else $error("reply did not start at once");
    a_reply_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_LOAD && tx_idx == 8'h00) |=> tx_shift[8:1] == slave_addr)
        else $error("reply address wrong");
    a_reply_func: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_LOAD && tx_idx == 8'h01) |=> (tx_shift[8:1] == `MB_FC_READ_HOLDING
        || tx_shift[8:1] == (`MB_FC_READ_HOLDING | `MB_FC_EXC_FLAG)))
        else $error("reply function code wrong");
    a_word_swap_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_LOAD && !resp_exc && resp_start == `MB_REG_PRESSURE && tx_idx == 8'h03)
        |=> tx_shift[8:1] == snap_p[15:8]) else $error("first value byte is not byte 1");
    a_word_high_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_LOAD && !resp_exc && resp_start == `MB_REG_PRESSURE && tx_idx == 8'h05)
        |=> tx_shift[8:1] == snap_p[31:24]) else $error("upper word high byte misplaced");
    a_unmapped_exc: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_state == TX_IDLE && rx_ok && rx_buf[1] == `MB_FC_READ_HOLDING
        && rx_count == 4'(`MB_REQ_BYTES) && {rx_buf[2], rx_buf[3]} == 16'h0004
        && {rx_buf[4], rx_buf[5]} == 16'h0001)
        |=> resp_exc && resp_code == `MB_EXC_ILLEGAL_ADDR) else $error("unmapped read accepted");
endmodule
`default_nettype wire

/* testbench/modbus_master_model.sv */
// Bus master model: sends read requests and collects replies on the shared line
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model #(
    parameter int BIT_CYCLES = 16,
    parameter int WAIT_CYCLES = 1000
) (
    input wire logic i_clk_sys,
    input wire logic i_bus,
    input wire logic i_bus_driven,
    output logic o_line
);
    int unsigned cycle = 0;
    int unsigned sent_at = 0;
    int stop_errs = 0;
    // Released line idles high, as the bus biasing pulls it there
    initial o_line = 1'b1;
    always @(posedge i_clk_sys) cycle <= cycle + 1;

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction

    // Wire order 1,0,3,2 rearranged for a big-endian host
    function automatic logic [31:0] to_big(input logic [7:0] b[4]);
        return {b[2], b[3], b[0], b[1]};
    endfunction

    // Same bytes laid out for a little-endian host
    function automatic logic [31:0] to_little(input logic [7:0] b[4]);
        return {b[1], b[0], b[3], b[2]};
    endfunction

    task automatic send_frame(input logic [7:0] q[$], input bit bad_crc);
        logic [15:0] c;
        logic [9:0] ch;
        c = crc16(q) ^ (bad_crc ? 16'h0001 : 16'h0000);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[n]) begin
            ch = {1'b1, q[n], 1'b0};
            for (int i = 0; i < 10; i++) begin // 8N1, LSB first
                @(negedge i_clk_sys);
                o_line = ch[i];
                repeat (BIT_CYCLES - 1) @(negedge i_clk_sys);
            end
        end
        sent_at = cycle;
    endtask

    task automatic collect(output logic [7:0] q[$], output int lat);
        int n;
        logic [7:0] b;
        q = {};
        lat = -1;
        n = 0;
        // A silent slave is given up on after a bounded wait
        while (!i_bus_driven && n < WAIT_CYCLES) begin
            @(posedge i_clk_sys);
            n++;
        end
        if (!i_bus_driven) return;
        lat = cycle - sent_at;
        while (i_bus_driven) begin
            @(posedge i_clk_sys);
            if (i_bus_driven && !i_bus) begin
                repeat (BIT_CYCLES / 2) @(posedge i_clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(posedge i_clk_sys);
                    b[i] = i_bus;
                end
                repeat (BIT_CYCLES) @(posedge i_clk_sys);
                if (i_bus !== 1'b1) stop_errs++;
                q.push_back(b);
            end
        end
    endtask
endmodule
`default_nettype wire

/* testbench/modbus_rtu_readout_slave_tb.sv */
// Self-checking bench for the RTU readout slave
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_readout_slave_tb;
    localparam int BITC = 16;
    localparam int GAP = 2 * 10 * BITC;
    typedef struct {logic [7:0] fc; logic [15:0] start; logic [15:0] qty; logic [7:0] exc;} row_t;
    row_t rows[10] = '{'{8'h03, 16'h0002, 16'h0002, 8'h00}, '{8'h03, 16'h0006, 16'h0004, 8'h00},
        '{8'h03, 16'h0003, 16'h0001, 8'h00}, '{8'h03, 16'h0008, 16'h0002, 8'h00},
        '{8'h03, 16'h0004, 16'h0001, 8'h02}, '{8'h03, 16'h0009, 16'h0002, 8'h02},
        '{8'h03, 16'h0006, 16'h0000, 8'h03}, '{8'h04, 16'h0002, 16'h0002, 8'h01},
        '{8'h03, 16'h0002, 16'h0009, 8'h02}, '{8'h03, 16'h0002, 16'h007E, 8'h03}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] serial = 32'h0001E241;
    logic [31:0] pres = 32'h4121_8A3C;
    logic [31:0] flow = 32'hC2F0_1357;
    logic [31:0] cons = 32'h0012_D687;
    logic tx, tx_en, m_line, bus;
    logic [7:0] slave_address;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    int lat;
    int n_fail = 0;
    int n_checks = 0;

    always #2.5 clk = ~clk;
    // Half duplex: the slave owns the line only while its driver is enabled
    assign bus = tx_en ? tx : m_line;

    modbus_rtu_readout_slave #(.BIT_CYCLES(BITC), .GAP_CHARS(2), .MAX_QTY(8)) dut (
        .i_clk_sys(clk), .i_rst(rst), .i_rx(bus), .i_serial_number(serial),
        .i_pressure_value(pres), .i_volumetric_flow_value(flow),
        .i_total_consumption_count(cons), .o_tx(tx), .o_tx_en(tx_en),
        .o_slave_address(slave_address));
    modbus_master_model #(.BIT_CYCLES(BITC), .WAIT_CYCLES(1000)) master (
        .i_clk_sys(clk), .i_bus(bus), .i_bus_driven(tx_en), .o_line(m_line));

    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$], input string msg);
        bit ok;
        ok = (g.size() == e.size());
        foreach (e[i]) if (ok && g[i] !== e[i]) ok = 1'b0;
        check(ok, msg);
    endtask

    function automatic logic [15:0] reg_word(input logic [15:0] r);
        case (r)
            16'h0002: return pres[15:0];
            16'h0003: return pres[31:16];
            16'h0006: return flow[15:0];
            16'h0007: return flow[31:16];
            16'h0008: return cons[15:0];
            16'h0009: return cons[31:16];
            default: return 16'h0000;
        endcase
    endfunction

    function automatic void expect_reply(input logic [7:0] adr, input row_t r,
                                         output logic [7:0] q[$]);
        logic [15:0] w;
        if (r.exc != 8'h00) begin
            // The slave serves only function 03, so every exception carries 03 with the flag
            q = {adr, 8'h03 | 8'h80, r.exc};
        end else begin
            q = {adr, r.fc, 8'(2 * r.qty)};
            for (int i = 0; i < r.qty; i++) begin
                w = reg_word(16'(r.start + i));
                q.push_back(w[15:8]);
                q.push_back(w[7:0]);
            end
        end
        w = master.crc16(q);
        q.push_back(w[7:0]);
        q.push_back(w[15:8]);
    endfunction

    task automatic transact(input logic [7:0] adr, input row_t r, input bit bad);
        master.send_frame({adr, r.fc, r.start[15:8], r.start[7:0], r.qty[15:8], r.qty[7:0]}, bad);
        master.collect(got, lat);
        // Inter-frame silence before the next request
        repeat (GAP + 8) @(negedge clk);
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (2) @(negedge clk);
        check(tx === 1'b1 && tx_en === 1'b0 && slave_address === 8'h00, "reset outputs");
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check(slave_address === 8'h39, "slave address");
        foreach (rows[i]) begin
            transact(8'h39, rows[i], 1'b0);
            expect_reply(8'h39, rows[i], exp);
            cmp_q(got, exp, "reply bytes");
            check(lat >= GAP - BITC && lat <= GAP + 8, "reply delay");
        end
        // A read frame of the wrong length is refused
        master.send_frame({8'h39, 8'h03, 8'h00, 8'h02}, 1'b0);
        master.collect(got, lat);
        repeat (GAP + 8) @(negedge clk);
        check(lat == -1, "reply to short read");
        transact(8'h39, rows[0], 1'b1);
        check(lat == -1, "reply to bad checksum");
        transact(8'h3A, rows[0], 1'b0);
        check(lat == -1, "reply to other address");
        transact(8'h00, rows[0], 1'b0);
        check(lat == -1, "reply to broadcast");
        // New measurements must be taken at the next request, not held over
        pres = 32'hBF80_0001;
        transact(8'h39, rows[0], 1'b0);
        check(got.size() == 9, "reply length");
        if (got.size() == 9) begin
            check(master.to_big('{got[3], got[4], got[5], got[6]}) === pres, "big");
            check(master.to_little('{got[3], got[4], got[5], got[6]}) === {<<8{pres}},
                  "little");
        end
        // Second reset picks up a new serial number
        serial = 32'h000003DB;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check(slave_address === 8'h57, "address after reset");
        transact(8'h57, rows[3], 1'b0);
        expect_reply(8'h57, rows[3], exp);
        cmp_q(got, exp, "reply after reset");
        check(master.stop_errs == 0, "reply stop bits");
        end_of_test();
    end
endmodule
`default_nettype wire
